/* File: core/high_port_pkg.sv */
// Purpose: shared constants and types for the upper-port gpio block
// Assumes: 8-bit special-register bus, page select held outside
// Notes:   addresses on the special-register page are parameters here
package high_port_pkg;
  localparam int unsigned NUM_PORTS = 5; // index 0 = port 3, 1..4 = ports 4..7
  localparam logic [7:0] HIGH_PAGE = 8'h0f;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam int unsigned PULLUP_DIS_BIT = 7;
  localparam logic [7:0] PORT4_PIN_MASK = 8'he0;
  // register addresses
  localparam logic [7:0] ADDR_PORT3_LATCH = 8'hb0;
  localparam logic [7:0] ADDR_PORT3_MODE = 8'ha7;
  localparam logic [7:0] ADDR_PORT4_LATCH = 8'hc8;
  localparam logic [7:0] ADDR_PORT4_MODE = 8'h9c;
  localparam logic [7:0] ADDR_P5_LATCH = 8'hd8;
  localparam logic [7:0] ADDR_P5_MODE = 8'h9d;
  localparam logic [7:0] ADDR_P6_LATCH = 8'he8;
  localparam logic [7:0] ADDR_P6_MODE = 8'h9e;
  localparam logic [7:0] ADDR_P7_LATCH = 8'hf8;
  localparam logic [7:0] ADDR_P7_MODE = 8'h9f;
  localparam logic [7:0] ADDR_CFG2 = 8'he3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic       active;
    logic       is_read;
    logic [7:0] en;   // pins taken over by the memory interface
    logic [7:0] val;  // level driven on those pins
    logic [7:0] bus;  // data bus pins released during reads
  } emif_port_t;
endpackage

/* File: core/pin_cell.sv */
// Purpose: one port pin's output, enable and pull-up logic
// Assumes: mode 1 = push-pull, 0 = open-drain
// Notes:   purely combinational
`timescale 1ns/1ps
module pin_cell
(
  input  wire logic latch_bit,
  input  wire logic mode_bit,
  input  wire logic ext_en,
  input  wire logic ext_val,
  input  wire logic bus_release,
  input  wire logic pu_global_off,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_en
);
  logic level;
  always_comb
  begin
    level = ext_en ? ext_val : latch_bit; // [R12]
    pin_out = level;
    if (bus_release)
    begin
      pin_oe = 1'b0; // [R13]
    end
    else
    begin
      pin_oe = mode_bit | ~level; // [R5] [R6]
    end
    pullup_en = ~pu_global_off & ~(pin_oe & ~level); // [R10] [R11]
  end
endmodule

/* File: core/high_port_gpio.sv */
// Purpose: gpio logic for port 3 and ports 4 through 7
// Assumes: registered pin levels, one-cycle read data latency
// Notes:   port index 0 is port 3, indices 1..4 are ports 4..7
// Function
// [R1] ports 4..7 registers answer only when page select equals the high page.
// [R2] port 4 has only pins 7..5; bits 4..0 drive no pin.
// [R3] a normal data read returns the pin levels.
// [R4] a read-modify-write read returns the latch contents.
// [R5] push-pull drives the latch level actively both ways.
// [R6] open-drain drives low for 0 and releases for 1.
// [R7] a mode bit of 1 selects push-pull, 0 open-drain.
// [R8] all mode bits clear on reset.
// [R9] software makes an input by open-drain and latch 1.
// [R10] weak pull-ups on unless the global disable bit is 1.
// [R11] pull-up off on any pin driven low.
// [R12] the memory interface overrides latch levels during its access.
// [R13] memory access keeps modes, but reads release the data bus.
// [R14] data registers and input paths exist even without pins; a normal read of unpinned port 4 bits returns the latch, not the input path.
// [R15] software should keep unbonded inputs from floating.
// [R16] data registers of ports 4..7 are whole-byte accessible.
// [R17] data latches reset to all ones.
`timescale 1ns/1ps
module high_port_gpio
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire high_port_pkg::sfr_req_t      sfr_req,
  output logic [7:0]                        sfr_rdata,
  output logic                              sfr_hit,
  input  wire high_port_pkg::emif_port_t [4:0] emif,
  input  wire logic [4:0][7:0]              pin_in,
  output logic [4:0][7:0]                   pin_out,
  output logic [4:0][7:0]                   pin_oe,
  output logic [4:0][7:0]                   pullup_en
);
  typedef struct packed {
    logic [4:0][7:0] latch;
    logic [4:0][7:0] mode;
    logic [7:0]      cfg2;
    logic [4:0][7:0] sync1;
    logic [4:0][7:0] sync2;
    logic [7:0]      rdata;
    logic            hit;
    logic [4:0][7:0] out;
    logic [4:0][7:0] oe;
    logic [4:0][7:0] pu;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [4:0][7:0] c_out;
  logic [4:0][7:0] c_oe;
  logic [4:0][7:0] c_pu;
  logic [4:0][7:0] latch_addr;
  logic [4:0][7:0] mode_addr;
  logic [4:0][7:0] pin_mask;

  assign latch_addr = {high_port_pkg::ADDR_P7_LATCH, high_port_pkg::ADDR_P6_LATCH,
                       high_port_pkg::ADDR_P5_LATCH, high_port_pkg::ADDR_PORT4_LATCH,
                       high_port_pkg::ADDR_PORT3_LATCH};
  assign mode_addr = {high_port_pkg::ADDR_P7_MODE, high_port_pkg::ADDR_P6_MODE,
                      high_port_pkg::ADDR_P5_MODE, high_port_pkg::ADDR_PORT4_MODE,
                      high_port_pkg::ADDR_PORT3_MODE};
  assign pin_mask = {8'hff, 8'hff, 8'hff, high_port_pkg::PORT4_PIN_MASK, 8'hff}; // [R2]

  genvar p;
  genvar b;
  generate
    for (p = 0; p < 5; p++)
    begin : g_port
      for (b = 0; b < 8; b++)
      begin : g_bit
        pin_cell u_cell
        (
          .latch_bit     (state_reg.latch[p][b]),
          .mode_bit      (state_reg.mode[p][b]),
          .ext_en        (emif[p].active & emif[p].en[b]),
          .ext_val       (emif[p].val[b]),
          .bus_release   (emif[p].active & emif[p].is_read & emif[p].bus[b]),
          .pu_global_off (state_reg.cfg2[high_port_pkg::PULLUP_DIS_BIT]),
          .pin_out       (c_out[p][b]),
          .pin_oe        (c_oe[p][b]),
          .pullup_en     (c_pu[p][b])
        );
      end
    end
  endgenerate

  always_comb
  begin
    logic page_ok;
    page_ok = 1'b0;
    state_next = state_reg;
    state_next.sync1 = pin_in;
    state_next.sync2 = state_reg.sync1; // [R14]
    state_next.hit = 1'b0;
    state_next.rdata = 8'h00;
    for (int i = 0; i < 5; i++)
    begin
      page_ok = (i == 0) || (sfr_req.page == high_port_pkg::HIGH_PAGE); // [R1]
      if (page_ok && sfr_req.addr == latch_addr[i])
      begin
        if (sfr_req.wr)
        begin
          state_next.latch[i] = sfr_req.wdata; // [R16]
        end
        if (sfr_req.rd)
        begin
          state_next.hit = 1'b1;
          if (sfr_req.rmw)
          begin
            state_next.rdata = state_reg.latch[i]; // [R4]
          end
          else
          begin
            // unpinned port 4 bits read back the latch
            state_next.rdata = (state_reg.sync2[i] & pin_mask[i]) |
                               (state_reg.latch[i] & ~pin_mask[i]); // [R3]
          end
        end
      end
      if (page_ok && sfr_req.addr == mode_addr[i])
      begin
        if (sfr_req.wr)
        begin
          state_next.mode[i] = sfr_req.wdata; // [R7]
        end
        if (sfr_req.rd)
        begin
          state_next.hit = 1'b1;
          state_next.rdata = state_reg.mode[i];
        end
      end
    end
    if (sfr_req.addr == high_port_pkg::ADDR_CFG2)
    begin
      if (sfr_req.wr)
      begin
        state_next.cfg2 = sfr_req.wdata;
      end
      if (sfr_req.rd)
      begin
        state_next.hit = 1'b1;
        state_next.rdata = state_reg.cfg2;
      end
    end
    for (int i = 0; i < 5; i++)
    begin
      state_next.out[i] = c_out[i] & pin_mask[i]; // [R2]
      state_next.oe[i] = c_oe[i] & pin_mask[i];
      state_next.pu[i] = c_pu[i] & pin_mask[i];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg.latch <= {5{high_port_pkg::LATCH_RESET}}; // [R17]
      state_reg.mode <= {5{high_port_pkg::MODE_RESET}}; // [R8]
      state_reg.cfg2 <= high_port_pkg::CFG2_RESET;
      state_reg.sync1 <= '0;
      state_reg.sync2 <= '0;
      state_reg.rdata <= 8'h00;
      state_reg.hit <= 1'b0;
      state_reg.out <= '0;
      state_reg.oe <= '0;
      state_reg.pu <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sfr_rdata = state_reg.rdata;
  assign sfr_hit = state_reg.hit;
  assign pin_out = state_reg.out;
  assign pin_oe = state_reg.oe;
  assign pullup_en = state_reg.pu;

  mode_reset_a : assert property (@(posedge clk) $fell(rst) |-> state_reg.mode == '0) // [R8]
    else $error("mode bits not clear after reset");
  latch_reset_a : assert property (@(posedge clk) $fell(rst) |-> state_reg.latch == '1) // [R17]
    else $error("latches not all ones after reset");
  port4_low_a : assert property (@(posedge clk) disable iff (rst)
    (state_reg.oe[1][4:0] == 5'h00) && (state_reg.pu[1][4:0] == 5'h00)) // [R2]
    else $error("port 4 low bits drive a pin");
  page_gate_a : assert property (@(posedge clk) disable iff (rst)
    sfr_req.wr && sfr_req.page != high_port_pkg::HIGH_PAGE
    && sfr_req.addr == high_port_pkg::ADDR_P5_LATCH
    && high_port_pkg::ADDR_P5_LATCH != high_port_pkg::ADDR_PORT3_LATCH
    && high_port_pkg::ADDR_P5_LATCH != high_port_pkg::ADDR_CFG2
    |=> $stable(state_reg.latch[2])) // [R1]
    else $error("port 5 written off its page");
  rmw_read_a : assert property (@(posedge clk) disable iff (rst)
    sfr_req.rd && sfr_req.rmw && sfr_req.page == high_port_pkg::HIGH_PAGE
    && sfr_req.addr == high_port_pkg::ADDR_P6_LATCH && !sfr_req.wr
    |=> sfr_rdata == $past(state_reg.latch[3])) // [R4]
    else $error("rmw read not from latch");
  pin_read_a : assert property (@(posedge clk) disable iff (rst)
    sfr_req.rd && !sfr_req.rmw && sfr_req.page == high_port_pkg::HIGH_PAGE
    && sfr_req.addr == high_port_pkg::ADDR_P7_LATCH
    |=> sfr_rdata == $past(state_reg.sync2[4])) // [R3]
    else $error("normal read not from pins");
  drive_low_a : assert property (@(posedge clk) disable iff (rst)
    !emif[2].active && (state_reg.latch[2][0] == 1'b0)
    |=> state_reg.oe[2][0] && !state_reg.out[2][0] && !state_reg.pu[2][0]) // [R6] [R11]
    else $error("latch 0 not driven low");
  open_drain_a : assert property (@(posedge clk) disable iff (rst)
    !emif[2].active && state_reg.latch[2][1] && !state_reg.mode[2][1]
    |=> !state_reg.oe[2][1]) // [R6] [R7]
    else $error("open-drain high not released");
  push_pull_a : assert property (@(posedge clk) disable iff (rst)
    !emif[2].active && state_reg.latch[2][1] && state_reg.mode[2][1]
    |=> state_reg.oe[2][1] && state_reg.out[2][1]) // [R5]
    else $error("push-pull high not driven");
  pullup_off_a : assert property (@(posedge clk) disable iff (rst)
    state_reg.cfg2[high_port_pkg::PULLUP_DIS_BIT] |=> state_reg.pu[0] == 8'h00) // [R10]
    else $error("pull-up on while disabled");
  emif_read_a : assert property (@(posedge clk) disable iff (rst)
    emif[4].active && emif[4].is_read && emif[4].bus[0] |=> !state_reg.oe[4][0]) // [R13]
    else $error("data bus driven during read");
endmodule

/* File: verif/pin_world.sv */
// Purpose: behavioural model of the wires and off-chip parts on the upper ports
// Assumes: one shared wire per pin, optional external pull-down by a far device
// Notes:   an undriven pin with no pull-up and no external pull-down toggles every cycle
`timescale 1ns/1ps
module pin_world
(
  input  wire logic            clk,
  input  wire logic [4:0][7:0] pin_out,
  input  wire logic [4:0][7:0] pin_oe,
  input  wire logic [4:0][7:0] pullup_en,
  input  wire logic [4:0][7:0] ext_low,
  output logic      [4:0][7:0] pin_lvl
);
  logic tgl = 1'b0;

  always @(posedge clk)
    tgl <= ~tgl;

  always_comb
    for (int p = 0; p < 5; p++)
      for (int b = 0; b < 8; b++)
        if (pin_oe[p][b])
          pin_lvl[p][b] = pin_out[p][b];
        else if (ext_low[p][b])
          pin_lvl[p][b] = 1'b0;
        else if (pullup_en[p][b])
          pin_lvl[p][b] = 1'b1;
        else
          pin_lvl[p][b] = tgl;
endmodule

/* File: verif/test_high_port_gpio.sv */
// Purpose: self-checking bench for the upper-port gpio block
// Assumes: pins modelled by pin_world
// Notes:   each scenario is one task
`timescale 1ns/1ps
module test_high_port_gpio;
  localparam logic [7:0] PF = high_port_pkg::HIGH_PAGE;
  logic                            clk = 1'b0;
  logic                            rst = 1'b1;
  high_port_pkg::sfr_req_t         req = '0;
  high_port_pkg::emif_port_t [4:0] emif = '0;
  logic [4:0][7:0]                 ext_low = '0;
  logic [4:0][7:0]                 pin_lvl, pin_out, pin_oe, pullup_en;
  logic [7:0]                      rdata;
  logic                            hit;
  int                              error_cnt = 0;
  int                              cmp_count = 0;
  int                              cyc = 0;

  initial forever #25 clk = ~clk;

  high_port_gpio DUT (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .sfr_hit(hit),
    .emif(emif), .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en));
  pin_world far (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_low(ext_low), .pin_lvl(pin_lvl));

  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // run ceiling, well above the scenario length
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, 1'b0, a, pg, d};
    @(posedge clk);
    req <= '0;
  endtask

  // exp is {hit, data}
  task automatic rd(input logic [7:0] a, input logic [7:0] pg, input logic m,
                    input logic [8:0] exp, input string s);
    @(posedge clk);
    req <= '{1'b0, 1'b1, m, a, pg, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk(rdata, exp[7:0], s);
    chk({7'h00, hit}, {7'h00, exp[8]}, s);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    chk(pullup_en[2], 8'hff, "pullup after reset");
    chk(pin_oe[2], 8'h00, "oe after reset");
    rd(high_port_pkg::ADDR_P5_MODE, PF, 1'b0, 9'h100, "mode reset");
    rd(high_port_pkg::ADDR_P5_LATCH, PF, 1'b1, 9'h1ff, "latch reset");
  endtask

  task automatic t_modes;
    wr(high_port_pkg::ADDR_P5_LATCH, PF, 8'h5a);
    wr(high_port_pkg::ADDR_P5_MODE, PF, 8'h0f);
    settle();
    chk(pin_oe[2], 8'haf, "mode oe");
    chk(pin_out[2] & pin_oe[2], 8'h0a, "driven levels");
    chk(pullup_en[2], 8'h5a, "pullup off when low");
    @(posedge clk);
    ext_low[2][6] <= 1'b1;
    settle();
    rd(high_port_pkg::ADDR_P5_LATCH, PF, 1'b0, 9'h11a, "pin read");
    rd(high_port_pkg::ADDR_P5_LATCH, PF, 1'b1, 9'h15a, "rmw read");
    @(posedge clk);
    ext_low <= '0;
  endtask

  task automatic t_page;
    wr(high_port_pkg::ADDR_P5_LATCH, 8'h00, 8'hff);
    rd(high_port_pkg::ADDR_P5_LATCH, 8'h00, 1'b1, 9'h000, "wrong page");
    rd(high_port_pkg::ADDR_P5_LATCH, PF, 1'b1, 9'h15a, "write ignored");
  endtask

  task automatic t_pullup;
    wr(high_port_pkg::ADDR_CFG2, 8'h00, 8'h80);
    settle();
    chk(pullup_en[2], 8'h00, "global pullup off");
    wr(high_port_pkg::ADDR_CFG2, 8'h00, 8'h00);
    settle();
    chk(pullup_en[2], 8'h5a, "pullup back on");
  endtask

  task automatic t_port4;
    wr(high_port_pkg::ADDR_PORT4_LATCH, PF, 8'h00);
    settle();
    chk(pin_oe[1], 8'he0, "port4 pins");
    rd(high_port_pkg::ADDR_PORT4_LATCH, PF, 1'b0, 9'h100, "port4 read");
    rd(high_port_pkg::ADDR_PORT3_LATCH, 8'h00, 1'b0, 9'h1ff, "port3 input");
    rd(high_port_pkg::ADDR_PORT3_LATCH, 8'h00, 1'b1, 9'h1ff, "port3 latch");
  endtask

  task automatic t_emif;
    wr(high_port_pkg::ADDR_P6_MODE, PF, 8'hff);
    wr(high_port_pkg::ADDR_P7_MODE, PF, 8'hff);
    @(posedge clk);
    emif[3] <= '{1'b1, 1'b0, 8'hff, 8'ha5, 8'h00};
    settle();
    chk(pin_out[3], 8'ha5, "emif levels");
    chk(pin_oe[3], 8'hff, "emif keeps mode");
    rd(high_port_pkg::ADDR_P6_LATCH, PF, 1'b0, 9'h1a5, "pins under emif");
    rd(high_port_pkg::ADDR_P6_LATCH, PF, 1'b1, 9'h1ff, "latch under emif");
    @(posedge clk);
    emif[3] <= '{1'b1, 1'b1, 8'hff, 8'ha5, 8'hff};
    emif[4] <= '{1'b1, 1'b1, 8'h00, 8'h00, 8'hff};
    settle();
    chk(pin_oe[3], 8'h00, "emif read releases");
    chk(pin_oe[4], 8'h00, "data bus released");
    rd(high_port_pkg::ADDR_P6_MODE, PF, 1'b0, 9'h1ff, "mode kept");
    @(posedge clk);
    emif <= '0;
    settle();
    chk(pin_out[3], 8'hff, "latch back");
    chk(pin_oe[4], 8'hff, "drivers back");
    rd(high_port_pkg::ADDR_P7_LATCH, PF, 1'b0, 9'h1ff, "port7 pins");
  endtask

  // second reset in mid-run
  task automatic t_rerst;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(pin_oe[4], 8'h00, "oe after rerst");
    rd(high_port_pkg::ADDR_P7_MODE, PF, 1'b0, 9'h100, "mode after rerst");
    rd(high_port_pkg::ADDR_PORT4_LATCH, PF, 1'b1, 9'h1ff, "latch after rerst");
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
    t_reset();
    t_modes();
    t_page();
    t_pullup();
    t_port4();
    t_emif();
    t_rerst();
    close_out();
  end
endmodule
